// ===== rtl/fds_ctrl.sv
// Floating-point dispatch, trap, synchronisation and detection control.
// Assumes the core offers one instruction at a time and holds it until accepted.
// How it works
// - Legacy mode: wait before FP op is no-op.
// - Split store fault: integrated commits first half only; the code commits it for every cp_type except FDS_CP_NEW32.
// - Each FP op waits for previous completion.
// - Redundant waits still execute correctly.
// - Serializing op waits until everything committed.
// - Sample error pin after reset, before FP.
// - Integrated unit signals no error on init.
// - Control word reads FFFF absent, 037F present.
// - Emulate clear dispatches, set traps.
// - Monitor set makes waits test task flag.
// - Emulate trap uses vector seven.
// - Native flag reports numeric errors internally.
`timescale 1ns/1ps
`default_nettype none
module fds_ctrl (
	// Clock and reset.
	input  wire logic             clk,
	input  wire logic             srst,
	// Control flags.
	input  wire logic             fp_emulate,
	input  wire logic             coproc_monitor,
	input  wire logic             numeric_error_native,
	input  wire logic             task_switched_flag,
	input  wire logic             legacy_mode,
	input  wire logic             fpu_present,
	// Instruction offer from the core.
	input  wire logic             op_valid,
	input  wire fds_pkg::fds_op_e op_kind,
	input  wire logic             op_is_init,
	input  wire logic             op_next_is_fp,
	output logic                  op_ready,
	// Commit status from the pipeline.
	input  wire logic             pipe_all_committed,
	// Floating-point unit side.
	output logic                  fpu_issue,
	input  wire logic             fpu_done,
	input  wire logic             fpu_exc,
	input  wire logic             fpu_error_n,
	// Split operand store.
	input  wire logic             split_store,
	input  wire logic             split_second_fault,
	output logic                  commit_first_half,
	// Results.
	output logic                  fault_valid,
	output logic [7:0]            fault_vector,
	output logic                  numeric_err_internal,
	output logic                  numeric_err_ext,
	output logic [15:0]           ctrl_word,
	output logic                  detect_done,
	output fds_pkg::fds_cp_e      cp_type
);
	import fds_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Error pin synchroniser and detection.

	logic err_meta_reg;
	logic err_sync_reg;

	always_ff @(posedge clk) begin
		if (srst) begin
			err_meta_reg <= 1'b1;
			err_sync_reg <= 1'b1;
		end else begin
			err_meta_reg <= fpu_error_n;
			err_sync_reg <= err_meta_reg;
		end
	end

	fds_detect u_detect (
		.clk         (clk),
		.srst        (srst),
		.err_n_sync  (err_sync_reg),
		.detect_done (detect_done),
		.cp_type     (cp_type)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Dispatch.

	logic        busy_reg;
	logic        busy_next;
	logic        pend_reg;
	logic        pend_next;
	logic        fault_reg;
	logic        fault_next;
	logic [7:0]  vec_reg;
	logic [7:0]  vec_next;
	logic        nint_reg;
	logic        nint_next;
	logic        next_reg;
	logic        next_next;
	logic [15:0] cw_reg;
	logic [15:0] cw_next;
	logic        fh_reg;
	logic        fh_next;
	logic        take;
	logic        issue;
	logic        wait_test;
	logic        report;

	// Waits and FP ops stall while the previous FP op runs; FP ops also wait for detection to finish.
	always_comb begin
		op_ready = 1'b1;
		unique case (op_kind)
			FDS_OP_NONE:   op_ready = 1'b1;
			FDS_OP_FP:     op_ready = detect_done && !busy_reg;
			FDS_OP_WAIT:   op_ready = !busy_reg;
			FDS_OP_SERIAL: op_ready = !busy_reg && pipe_all_committed;
		endcase
	end

	assign take      = op_valid && op_ready;
	assign wait_test = coproc_monitor && task_switched_flag;
	// A pending exception is reported by the waiting op, unless legacy mode lets a
	// wait that leads an FP op pass as a no-op and the FP op report it instead.
	assign report    = take && pend_reg && !(op_kind == FDS_OP_WAIT && wait_test)
		&& (op_kind == FDS_OP_FP
		|| (op_kind == FDS_OP_WAIT && !(legacy_mode && op_next_is_fp)));
	assign issue     = take && op_kind == FDS_OP_FP && !fp_emulate && !report;

	always_comb begin
		busy_next  = busy_reg;
		pend_next  = pend_reg;
		fault_next = 1'b0;
		vec_next   = vec_reg;
		nint_next  = 1'b0;
		next_next  = 1'b0;
		cw_next    = cw_reg;
		fh_next    = 1'b0;
		if (busy_reg && fpu_done) begin
			busy_next = 1'b0;
			// Integrated unit and old coprocessor flag no error for init.
			if (fpu_exc) begin
				pend_next = 1'b1;
			end
		end
		if (take && op_kind == FDS_OP_FP && fp_emulate) begin
			fault_next = 1'b1;
			vec_next   = VEC_DEV_UNAVAIL;
		end else if (take && op_kind == FDS_OP_WAIT && wait_test) begin
			fault_next = 1'b1;
			vec_next   = VEC_DEV_UNAVAIL;
		end else if (report) begin
			pend_next = 1'b0;
			nint_next = numeric_error_native;
			next_next = !numeric_error_native;
		end
		if (issue) begin
			busy_next = 1'b1;
			if (op_is_init) begin
				cw_next = CW_INIT;
				pend_next = 1'b0;
			end
		end
		if (take && op_kind == FDS_OP_FP && op_is_init && !issue && !report) begin
			cw_next = fpu_present ? CW_ADDON_FPU : CW_NO_FPU;
		end
		if (!fpu_present && take && op_kind == FDS_OP_FP && op_is_init) begin
			cw_next = CW_NO_FPU;
		end
		// The 32-bit external coprocessor stores nothing on a split fault.
		fh_next = split_store && split_second_fault && cp_type != FDS_CP_NEW32;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			busy_reg  <= 1'b0;
			pend_reg  <= 1'b0;
			fault_reg <= 1'b0;
			vec_reg   <= 8'h00;
			nint_reg  <= 1'b0;
			next_reg  <= 1'b0;
			cw_reg    <= CW_NO_FPU;
			fh_reg    <= 1'b0;
		end else begin
			busy_reg  <= busy_next;
			pend_reg  <= pend_next;
			fault_reg <= fault_next;
			vec_reg   <= vec_next;
			nint_reg  <= nint_next;
			next_reg  <= next_next;
			cw_reg    <= cw_next;
			fh_reg    <= fh_next;
		end
	end

	assign fpu_issue            = issue;
	assign fault_valid          = fault_reg;
	assign fault_vector         = vec_reg;
	assign numeric_err_internal = nint_reg;
	assign numeric_err_ext      = next_reg;
	assign ctrl_word            = cw_reg;
	assign commit_first_half    = fh_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	property p_sync;
		@(posedge clk) disable iff (srst) busy_reg |-> !fpu_issue;
	endproperty
	a_sync: assert property (p_sync) else $error("FP op issued while previous busy");

	property p_emul;
		@(posedge clk) disable iff (srst)
		(take && op_kind == FDS_OP_FP && fp_emulate) |=> (fault_valid && fault_vector == VEC_DEV_UNAVAIL);
	endproperty
	a_emul: assert property (p_emul) else $error("Emulate did not trap on vector 7");

	property p_noissue_emul;
		@(posedge clk) disable iff (srst) fp_emulate |-> !fpu_issue;
	endproperty
	a_noissue_emul: assert property (p_noissue_emul) else $error("Issued while emulating");

	property p_ts;
		@(posedge clk) disable iff (srst)
		(take && op_kind == FDS_OP_WAIT && coproc_monitor && task_switched_flag) |=> fault_valid;
	endproperty
	a_ts: assert property (p_ts) else $error("Wait ignored set task flag");

	property p_ts_ignore;
		@(posedge clk) disable iff (srst)
		(take && op_kind == FDS_OP_WAIT && !coproc_monitor && !pend_reg) |=> !fault_valid;
	endproperty
	a_ts_ignore: assert property (p_ts_ignore) else $error("Wait faulted with monitor off");

	property p_serial;
		@(posedge clk) disable iff (srst)
		(op_kind == FDS_OP_SERIAL && !pipe_all_committed) |-> !op_ready;
	endproperty
	a_serial: assert property (p_serial) else $error("Serializing op passed early");

	property p_detect;
		@(posedge clk) disable iff (srst) (op_kind == FDS_OP_FP && !detect_done) |-> !op_ready;
	endproperty
	a_detect: assert property (p_detect) else $error("FP op before detection");

	property p_cw;
		@(posedge clk) disable iff (srst)
		(take && op_kind == FDS_OP_FP && op_is_init && !fpu_present) |=> ctrl_word == CW_NO_FPU;
	endproperty
	a_cw: assert property (p_cw) else $error("Absent unit control word wrong");

	property p_split;
		@(posedge clk) disable iff (srst)
		(split_store && split_second_fault && cp_type == FDS_CP_NEW32) |=> !commit_first_half;
	endproperty
	a_split: assert property (p_split) else $error("Half store kept with 32-bit unit");

	property p_native;
		@(posedge clk) disable iff (srst) numeric_err_internal |-> $past(numeric_error_native);
	endproperty
	a_native: assert property (p_native) else $error("Internal report without native flag");
endmodule : fds_ctrl
`default_nettype wire

// ===== rtl/fds_detect.sv
// Coprocessor type detection after reset.
// Assumes fpu_error_n is already synchronised to clk by the caller.
`timescale 1ns/1ps
`default_nettype none
module fds_detect (
	// Clock and reset.
	input  wire logic             clk,
	input  wire logic             srst,
	// Error pin level, synchronised.
	input  wire logic             err_n_sync,
	// Result.
	output logic                  detect_done,
	output fds_pkg::fds_cp_e      cp_type
);
	import fds_pkg::*;

	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;
	logic       done_reg;
	logic       done_next;
	fds_cp_e    type_reg;
	fds_cp_e    type_next;

	// The pin is sampled once, a fixed delay after reset release, so a slow coprocessor
	// has settled its error output before it is read.
	always_comb begin
		cnt_next  = cnt_reg;
		done_next = done_reg;
		type_next = type_reg;
		if (!done_reg) begin
			if (cnt_reg == 8'(DETECT_CYCLES)) begin
				done_next = 1'b1;
				type_next = err_n_sync ? FDS_CP_OLD16 : FDS_CP_NEW32;
			end else begin
				cnt_next = cnt_reg + 8'h01;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_reg  <= 8'h00;
			done_reg <= 1'b0;
			type_reg <= FDS_CP_UNKNOWN;
		end else begin
			cnt_reg  <= cnt_next;
			done_reg <= done_next;
			type_reg <= type_next;
		end
	end

	assign detect_done = done_reg;
	assign cp_type     = type_reg;
endmodule : fds_detect
`default_nettype wire

// ===== rtl/fds_pkg.sv
// Constants shared by the dispatch and synchronisation control block.
// Assumes a single 50 MHz core clock domain.
package fds_pkg;
	localparam logic [7:0]  VEC_DEV_UNAVAIL = 8'h07;
	localparam logic [15:0] CW_NO_FPU       = 16'hFFFF;
	localparam logic [15:0] CW_ADDON_FPU    = 16'h037F;
	localparam logic [15:0] CW_INIT         = 16'h037F;
	localparam int unsigned DETECT_DELAY_NS = 200;
	localparam int unsigned CLK_PERIOD_NS   = 20;
	localparam int unsigned DETECT_CYCLES   = (DETECT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Kind of instruction offered to the block.
	typedef enum logic [1:0] {
		FDS_OP_NONE  = 2'b00,
		FDS_OP_FP    = 2'b01,
		FDS_OP_WAIT  = 2'b10,
		FDS_OP_SERIAL = 2'b11
	} fds_op_e;

	// Coprocessor type found at reset.
	typedef enum logic [1:0] {
		FDS_CP_UNKNOWN = 2'b00,
		FDS_CP_OLD16   = 2'b01,
		FDS_CP_NEW32   = 2'b10
	} fds_cp_e;
endpackage : fds_pkg

// ===== tb/fds_fpu_model.sv
// Behavioural external floating-point unit of either the 16-bit or the 32-bit type.
// Assumes issue is a one-cycle pulse in the clk domain.
`timescale 1ns/1ps
`default_nettype none
module fds_fpu_model #(
	parameter int DLY = 3
) (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic srst,
	// Unit side.
	input  wire logic issue,
	input  wire logic is32,
	input  wire logic exc_req,
	output logic      done,
	output logic      exc,
	output logic      error_n
);
	int cnt;
	always_ff @(posedge clk) begin
		if (srst)
			cnt <= 0;
		else if (issue)
			cnt <= DLY;
		else if (cnt != 0)
			cnt <= cnt - 1;
	end
	assign done = (cnt == 1);
	// An exception is reported with completion while the bench asks for one.
	assign exc = done && exc_req;
	// The 16-bit type keeps the error pin inactive after reset, the 32-bit type active.
	assign error_n = !is32;
endmodule : fds_fpu_model
`default_nettype wire

// ===== tb/test_fpu_dispatch_sync_control.sv
// Self-checking bench for the dispatch and synchronisation control.
// Assumes the behavioural unit model answers every issue.
`timescale 1ns/1ps
`default_nettype none
module test_fpu_dispatch_sync_control;
	import fds_pkg::*;
	logic clk = 0, srst = 1, emu = 0, mon = 0, tsf = 0, pres = 1;
	logic v = 0, init = 0, nfp = 0, rdy, iss, done, exc, errn;
	logic ne = 1, leg = 0, pac = 1, sst = 0, ssf = 0, is32 = 0, xr = 0;
	logic cfh, fv, nei, nee, dd;
	logic [7:0] vec;
	logic [15:0] cw;
	fds_op_e k = FDS_OP_NONE;
	fds_cp_e cpt;
	int failures = 0, n_checks = 0;
	logic got;
	always #10 clk = ~clk;
	fds_ctrl uut (.clk(clk), .srst(srst), .fp_emulate(emu),
		.coproc_monitor(mon), .numeric_error_native(ne),
		.task_switched_flag(tsf), .legacy_mode(leg), .fpu_present(pres),
		.op_valid(v), .op_kind(k), .op_is_init(init), .op_next_is_fp(nfp),
		.op_ready(rdy), .pipe_all_committed(pac), .fpu_issue(iss),
		.fpu_done(done), .fpu_exc(exc), .fpu_error_n(errn),
		.split_store(sst), .split_second_fault(ssf),
		.commit_first_half(cfh), .fault_valid(fv), .fault_vector(vec),
		.numeric_err_internal(nei), .numeric_err_ext(nee), .ctrl_word(cw),
		.detect_done(dd), .cp_type(cpt));
	fds_fpu_model fpu (.clk(clk), .srst(srst), .issue(iss), .is32(is32),
		.exc_req(xr), .done(done), .exc(exc), .error_n(errn));
	task finish_test;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : finish_test
	task bad(input string m);
		failures++;
		$display("unexpected at %0t: %s", $time, m);
	endtask : bad
	// Offers one op and holds it until the edge that takes it.
	task op(input fds_op_e kind, input logic is_init);
		int i;
		@(posedge clk);
		v <= 1'b1;
		k <= kind;
		init <= is_init;
		for (i = 0; i < 60; i++) begin
			@(negedge clk);
			if (rdy === 1'b1)
				break;
		end
		if (i == 60) begin
			bad("op never taken");
			finish_test();
		end
		got = iss;
		@(posedge clk);
		v <= 1'b0;
		@(negedge clk);
	endtask : op
	task t_detect(input fds_cp_e want);
		int i;
		for (i = 0; i < 40 && dd !== 1'b1; i++)
			@(negedge clk);
		if (dd !== 1'b1) begin
			bad("detection never finished");
			finish_test();
		end
		n_checks++;
		if (cpt !== want)
			bad("detection");
		$display("test detect done");
	endtask : t_detect
	task t_trap;
		@(posedge clk);
		emu <= 1'b1;
		op(FDS_OP_FP, 1'b0);
		n_checks++;
		if (got !== 1'b0 || fv !== 1'b1)
			bad("no trap");
		n_checks++;
		if (vec !== VEC_DEV_UNAVAIL)
			bad("vector");
		@(posedge clk);
		emu <= 1'b0;
		$display("test trap done");
	endtask : t_trap
	task t_sync;
		op(FDS_OP_FP, 1'b0);
		n_checks++;
		if (got !== 1'b1 || rdy !== 1'b0 || fv !== 1'b0)
			bad("dispatch");
		op(FDS_OP_WAIT, 1'b0);
		op(FDS_OP_FP, 1'b1);
		n_checks++;
		if (got !== 1'b1)
			bad("second issue");
		repeat (8) @(negedge clk);
		n_checks++;
		if (cw !== CW_ADDON_FPU)
			bad("control word");
		$display("test sync done");
	endtask : t_sync
	task t_absent;
		@(posedge clk);
		pres <= 1'b0;
		emu <= 1'b1;
		mon <= 1'b0;
		ne <= 1'b1;
		op(FDS_OP_FP, 1'b1);
		n_checks++;
		if (got !== 1'b0 || fv !== 1'b1 || cw !== CW_NO_FPU)
			bad("absent unit");
		@(posedge clk);
		pres <= 1'b1;
		emu <= 1'b0;
		mon <= 1'b1;
		$display("test absent done");
	endtask : t_absent
	task t_monitor;
		@(posedge clk);
		tsf <= 1'b1;
		mon <= 1'b1;
		op(FDS_OP_WAIT, 1'b0);
		n_checks++;
		if (fv !== 1'b1 || vec !== VEC_DEV_UNAVAIL)
			bad("task flag ignored");
		@(posedge clk);
		mon <= 1'b0;
		emu <= 1'b1;
		op(FDS_OP_WAIT, 1'b0);
		n_checks++;
		if (fv !== 1'b0)
			bad("task flag tested");
		@(posedge clk);
		tsf <= 1'b0;
		emu <= 1'b0;
		$display("test monitor done");
	endtask : t_monitor
	task t_split(input logic want);
		@(posedge clk);
		sst <= 1'b1;
		ssf <= 1'b1;
		@(posedge clk);
		sst <= 1'b0;
		ssf <= 1'b0;
		@(negedge clk);
		n_checks++;
		if (cfh !== want)
			bad("split store");
		$display("test split done");
	endtask : t_split
	task t_native;
		@(posedge clk);
		xr <= 1'b1;
		ne <= 1'b1;
		op(FDS_OP_FP, 1'b0);
		op(FDS_OP_WAIT, 1'b0);
		n_checks++;
		if (nei !== 1'b1 || nee !== 1'b0)
			bad("native report");
		@(posedge clk);
		ne <= 1'b0;
		op(FDS_OP_FP, 1'b0);
		op(FDS_OP_WAIT, 1'b0);
		n_checks++;
		if (nei !== 1'b0 || nee !== 1'b1)
			bad("external report");
		$display("test native done");
	endtask : t_native
	task t_legacy;
		@(posedge clk);
		ne <= 1'b1;
		leg <= 1'b1;
		nfp <= 1'b1;
		op(FDS_OP_FP, 1'b0);
		op(FDS_OP_WAIT, 1'b0);
		n_checks++;
		if (nei !== 1'b0)
			bad("legacy wait reported");
		op(FDS_OP_FP, 1'b0);
		n_checks++;
		if (got !== 1'b0 || nei !== 1'b1)
			bad("legacy report missing");
		@(posedge clk);
		leg <= 1'b0;
		nfp <= 1'b0;
		xr <= 1'b0;
		$display("test legacy done");
	endtask : t_legacy
	task t_serial;
		@(posedge clk);
		pac <= 1'b0;
		k <= FDS_OP_SERIAL;
		v <= 1'b1;
		repeat (3) begin
			@(negedge clk);
			n_checks++;
			if (rdy !== 1'b0)
				bad("serializing op passed early");
		end
		@(posedge clk);
		pac <= 1'b1;
		v <= 1'b0;
		op(FDS_OP_SERIAL, 1'b0);
		n_checks++;
		if (got !== 1'b0 || fv !== 1'b0)
			bad("serializing op");
		$display("test serial done");
	endtask : t_serial
	task t_reset32;
		@(posedge clk);
		srst <= 1'b1;
		is32 <= 1'b1;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		@(negedge clk);
		n_checks++;
		if (dd !== 1'b0 || cpt !== FDS_CP_UNKNOWN || cw !== CW_NO_FPU)
			bad("state after reset");
		$display("test reset done");
		t_detect(FDS_CP_NEW32);
	endtask : t_reset32
	initial begin
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		t_detect(FDS_CP_OLD16);
		t_trap();
		t_sync();
		t_absent();
		t_monitor();
		t_split(1'b1);
		t_native();
		t_legacy();
		t_serial();
		t_reset32();
		t_split(1'b0);
		finish_test();
	end
endmodule : test_fpu_dispatch_sync_control
`default_nettype wire
